// ---- inc/mhic_pkg.sv ----
package mhic_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned RTC_PERIOD_MS = 10;
  localparam int unsigned SCAN_PERIOD_MS = 50;
  localparam int unsigned RTC_CYCLES    = CLK_HZ / 1000 * RTC_PERIOD_MS;
  localparam int unsigned SCAN_CYCLES   = CLK_HZ / 1000 * SCAN_PERIOD_MS;
  localparam int unsigned RTC_CW        = 18;
  localparam int unsigned SCAN_CW       = 21;

  // instruction pin lanes
  localparam int unsigned PIN_RST  = 0;
  localparam int unsigned PIN_CLR  = 1;
  localparam int unsigned PIN_PLS  = 2;
  localparam int unsigned PIN_STA  = 3;
  localparam int unsigned PIN_DOA  = 4;
  localparam int unsigned PIN_DOB  = 5;
  localparam int unsigned PIN_DOC  = 6;
  localparam int unsigned PIN_DIA  = 7;
  localparam int unsigned NUM_PINS = 8;

  // status stack
  localparam int unsigned STACK_DEPTH = 40;
  localparam int unsigned STACK_CW    = 6;
  localparam int unsigned ENTRY_W     = 9;
  localparam int unsigned PORT_ID_W   = 7;

  // status word, word bit 15 is the leftmost bit of the cpu word
  localparam int unsigned SW_RTC   = 15;
  localparam int unsigned SW_OVF   = 14;
  localparam int unsigned SW_IN    = 13;
  localparam int unsigned SW_OUT   = 12;
  localparam int unsigned SW_PORT  = 5;

  localparam logic [15:0] BASE_DEFAULT  = 16'h3c00;
  localparam int unsigned BASE_KEEP_LSB = 8;
  localparam logic [3:0]  CONSOLE_FMT   = 4'hb;  // 8 bits, no parity, 2 stop
  localparam logic [2:0]  RATE_RESET    = 3'h7;

  // apb map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_BASE = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam int unsigned CTRL_CLR  = 0;
  localparam int unsigned CTRL_RTC  = 1;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_RUN     = 2'b01,
    ST_PAUSING = 2'b11,
    ST_PAUSED  = 2'b10
  } mhic_run_t;

endpackage : mhic_pkg

// ---- verilog/mhic_stack.sv ----
`timescale 1ns/100ps
module mhic_stack #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 40,
  parameter int unsigned CW    = 6
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             pop_i,
  input  wire logic             flush_i,
  output logic      [WIDTH-1:0] head_o,
  output logic      [CW-1:0]    count_o,
  output logic                  full_o,
  output logic                  empty_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [CW-1:0]    wr_reg;
  logic [CW-1:0]    rd_reg;
  logic             do_push;
  logic             do_pop;

  function automatic logic [CW-1:0] wrap_inc(input logic [CW-1:0] v);
    return (v == CW'(DEPTH - 1)) ? '0 : v + 1'b1;
  endfunction : wrap_inc

  // a push into a full stack is dropped; the caller flags overflow
  assign do_push = push_i && !full_o && !flush_i;
  assign do_pop  = pop_i && !empty_o && !flush_i;
  assign full_o  = (count_o == CW'(DEPTH));
  assign empty_o = (count_o == '0);
  assign head_o  = mem_reg[rd_reg];

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem_reg[wr_reg] <= data_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      count_o <= '0;
    end else if (flush_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      count_o <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= wrap_inc(wr_reg);
      end
      if (do_pop) begin
        rd_reg <= wrap_inc(rd_reg);
      end
      count_o <= count_o + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule : mhic_stack

// ---- verilog/mhic_host_ctrl.sv ----
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module mhic_host_ctrl #(
  parameter int unsigned RTC_CYCLES  = mhic_pkg::RTC_CYCLES,
  parameter int unsigned SCAN_CYCLES = mhic_pkg::SCAN_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        bus_reset_instr_i,
  input  wire logic        no_xfer_clear_instr_i,
  input  wire logic        io_pulse_strobe_i,
  input  wire logic        no_xfer_start_instr_i,
  input  wire logic        data_out_a_instr_i,
  input  wire logic        data_out_b_instr_i,
  input  wire logic        data_out_c_instr_i,
  input  wire logic        data_in_a_instr_i,
  input  wire logic [15:0] data_bus_i,
  input  wire logic [2:0]  console_rate_strap_i,
  input  wire logic        report_valid_i,
  input  wire logic        report_in_done_i,
  input  wire logic        report_out_done_i,
  input  wire logic [mhic_pkg::PORT_ID_W-1:0] report_port_i,
  input  wire logic        port_in_service_i,
  output logic [15:0]      status_word_o,
  output logic [15:0]      base_addr_o,
  output logic             xfer_grant_o,
  output logic             done_o,
  output logic             busy_o,
  output logic             intr_o,
  output logic             rtc_run_o,
  output logic             scan_o,
  output logic             abort_tx_o,
  output logic             ctrl_assert_o,
  output logic             console_load_o,
  output logic [2:0]       console_rate_o,
  output logic [3:0]       console_fmt_o
);
  import mhic_pkg::*;

  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic [NUM_PINS-1:0] sync3_reg;
  logic [NUM_PINS-1:0] stb;
  logic [15:0]         dbus1_reg;
  logic [15:0]         dbus2_reg;
  logic [2:0]          strap1_reg;
  logic [2:0]          strap2_reg;
  logic                soft_clr;
  logic                soft_rtc;
  logic                clr_any;
  logic                rtc_start;
  mhic_run_t           state_reg;
  mhic_run_t           state_next;
  logic [RTC_CW-1:0]   rtc_cnt_reg;
  logic [SCAN_CW-1:0]  scan_cnt_reg;
  logic                rtc_tick;
  logic                rtc_flag_reg;
  logic                ovf_reg;
  logic                st_push;
  logic                st_pop;
  logic                st_flush;
  logic [ENTRY_W-1:0]  st_head;
  logic [STACK_CW-1:0] st_count;
  logic                st_full;
  logic                st_empty;
  logic                done_level;
  logic                apb_setup;
  logic                apb_write;
  logic [31:0]         rd_mux;
  logic                addr_ok;

  assign pins = {data_in_a_instr_i, data_out_c_instr_i, data_out_b_instr_i,
                 data_out_a_instr_i, no_xfer_start_instr_i, io_pulse_strobe_i,
                 no_xfer_clear_instr_i, bus_reset_instr_i};

  // bus pins are asynchronous; edge taken from the second and third stages
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      sync3_reg  <= '0;
      dbus1_reg  <= '0;
      dbus2_reg  <= '0;
      strap1_reg <= '0;
      strap2_reg <= '0;
    end else begin
      sync1_reg  <= pins;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      dbus1_reg  <= data_bus_i;
      dbus2_reg  <= dbus1_reg;
      strap1_reg <= console_rate_strap_i;
      strap2_reg <= strap1_reg;
    end
  end

  assign stb = sync2_reg & ~sync3_reg;

  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pwrite_i && pready_o;
  assign soft_clr  = apb_write && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_CLR];
  assign soft_rtc  = apb_write && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_RTC];
  assign clr_any   = stb[PIN_RST] || stb[PIN_CLR] || soft_clr;
  assign rtc_start = stb[PIN_PLS] || soft_rtc;

  // run and pause sequencing; start wins over a pause in the same cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (stb[PIN_DOC]) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (stb[PIN_DOB] && !stb[PIN_DOC]) begin
          state_next = port_in_service_i ? ST_PAUSING : ST_PAUSED;
        end
      end
      ST_PAUSING: begin
        if (stb[PIN_DOC]) state_next = ST_RUN;
        else if (!port_in_service_i) state_next = ST_PAUSED;
      end
      ST_PAUSED: begin
        if (stb[PIN_DOC]) state_next = ST_RUN;
      end
    endcase
    if (clr_any) state_next = ST_OFF;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg    <= ST_OFF;
      xfer_grant_o <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      state_reg <= state_next;
      // pausing only blocks new ports; characters in flight are untouched
      xfer_grant_o <= (state_next == ST_RUN);
      busy_o       <= (state_next != ST_OFF);
    end
  end

  // real-time clock
  assign rtc_tick = rtc_run_o && (rtc_cnt_reg == RTC_CW'(RTC_CYCLES - 1));

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rtc_run_o   <= 1'b0;
      rtc_cnt_reg <= '0;
    end else if (clr_any) begin
      rtc_run_o   <= 1'b0;
      rtc_cnt_reg <= '0;
    end else begin
      if (rtc_start) rtc_run_o <= 1'b1;
      if (!rtc_run_o || rtc_tick) rtc_cnt_reg <= '0;
      else rtc_cnt_reg <= rtc_cnt_reg + 1'b1;
    end
  end

  // periodic and prompted output scan, only while the core is on
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scan_cnt_reg <= '0;
      scan_o       <= 1'b0;
    end else if (state_reg == ST_OFF || clr_any) begin
      scan_cnt_reg <= '0;
      scan_o       <= 1'b0;
    end else if (stb[PIN_DOA]) begin
      scan_cnt_reg <= '0;
      scan_o       <= 1'b1;
    end else if (scan_cnt_reg == SCAN_CW'(SCAN_CYCLES - 1)) begin
      scan_cnt_reg <= '0;
      scan_o       <= 1'b1;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 1'b1;
      scan_o       <= 1'b0;
    end
  end

  // base address, reset-only effects and the transmit abort on any clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      base_addr_o    <= BASE_DEFAULT;
      ctrl_assert_o  <= 1'b0;
      console_load_o <= 1'b0;
      console_rate_o <= RATE_RESET;
      console_fmt_o  <= CONSOLE_FMT;
      abort_tx_o     <= 1'b0;
    end else begin
      ctrl_assert_o  <= stb[PIN_RST];
      console_load_o <= stb[PIN_RST];
      abort_tx_o     <= clr_any;
      if (stb[PIN_RST]) begin
        base_addr_o    <= BASE_DEFAULT;
        console_rate_o <= strap2_reg;
        console_fmt_o  <= CONSOLE_FMT;
      end else if (stb[PIN_DOA] && state_reg == ST_OFF && !clr_any) begin
        base_addr_o <= {dbus2_reg[15:BASE_KEEP_LSB],
                        BASE_KEEP_LSB'(0)};
      end
    end
  end

  // interrupt status stack
  assign st_flush = clr_any || (stb[PIN_STA] && ovf_reg);
  assign st_pop   = stb[PIN_STA];
  assign st_push  = report_valid_i;

  mhic_stack #(
    .WIDTH (ENTRY_W),
    .DEPTH (STACK_DEPTH),
    .CW    (STACK_CW)
  ) u_stack (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .push_i   (st_push),
    .data_i   ({report_in_done_i, report_out_done_i, report_port_i}),
    .pop_i    (st_pop),
    .flush_i  (st_flush),
    .head_o   (st_head),
    .count_o  (st_count),
    .full_o   (st_full),
    .empty_o  (st_empty)
  );

  // flags: a hardware set wins over a DIA or STA clear in the same cycle; a core clear wins over the set
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_reg      <= 1'b0;
      rtc_flag_reg <= 1'b0;
    end else begin
      if (st_push && st_full && !clr_any) ovf_reg <= 1'b1;
      else if (st_flush) ovf_reg <= 1'b0;
      if (rtc_tick && !clr_any) rtc_flag_reg <= 1'b1;
      else if (stb[PIN_DIA] || clr_any) rtc_flag_reg <= 1'b0;
    end
  end

  assign done_level = !st_empty || ovf_reg || rtc_flag_reg;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_o        <= 1'b0;
      intr_o        <= 1'b0;
      status_word_o <= '0;
    end else begin
      done_o <= done_level && !clr_any;
      intr_o <= !clr_any && ((done_level && !done_o) ||
                (st_pop && !st_flush && st_count > STACK_CW'(1)));
      status_word_o <= '0;
      status_word_o[SW_RTC] <= rtc_flag_reg;
      status_word_o[SW_OVF] <= ovf_reg;
      if (!st_empty && !ovf_reg) begin
        status_word_o[SW_IN]  <= st_head[ENTRY_W-1];
        status_word_o[SW_OUT] <= st_head[ENTRY_W-2];
        status_word_o[SW_PORT +: PORT_ID_W] <= st_head[PORT_ID_W-1:0];
      end
    end
  end

  // apb slave: zero wait states, read data prepared in the setup cycle
  always_comb begin
    rd_mux  = '0;
    addr_ok = 1'b1;
    unique case (paddr_i)
      ADDR_CTRL: rd_mux = {16'h0, 2'h0, st_count, ovf_reg, done_o, busy_o,
                           rtc_run_o, xfer_grant_o, 1'b0, state_reg};
      ADDR_BASE: rd_mux = {16'h0, base_addr_o};
      ADDR_STAT: rd_mux = {16'h0, status_word_o};
      default:   addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup && !addr_ok;
      if (apb_setup && !pwrite_i) prdata_o <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_pause_taken;
    stb[PIN_DOB] && !stb[PIN_DOC] && !clr_any && state_reg == ST_RUN;
  endsequence

  sequence s_still_serving;
    (port_in_service_i && !stb[PIN_DOC] && !clr_any) [*2];
  endsequence

  a_clear_stops_all: assert property (clr_any |=> state_reg == ST_OFF
      && !rtc_run_o && !done_o ##1 !busy_o && !xfer_grant_o)
    else $error("clear did not stop core, clock and flags");

  a_clear_abort_tx: assert property (clr_any |=> abort_tx_o)
    else $error("clear did not abort transmission");

  a_reset_defaults: assert property (stb[PIN_RST] |=> ctrl_assert_o
      && console_load_o && base_addr_o == BASE_DEFAULT)
    else $error("bus reset defaults not applied");

  a_clear_keeps_base: assert property (stb[PIN_CLR] && !stb[PIN_RST]
      |=> $stable(base_addr_o) && !ctrl_assert_o)
    else $error("clear disturbed reset-only settings");

  a_pulse_rtc_only: assert property (stb[PIN_PLS] && !clr_any
      && !stb[PIN_DOC] && !stb[PIN_DOB] && state_reg != ST_PAUSING |=>
      rtc_run_o && state_reg == $past(state_reg))
    else $error("pulse did not only start the clock");

  a_doa_loads_base: assert property (stb[PIN_DOA] && !clr_any
      && !stb[PIN_RST] && state_reg == ST_OFF
      |=> base_addr_o == {$past(dbus2_reg[15:8]), 8'h00})
    else $error("base not loaded from high data bits");

  a_doa_prompts: assert property (stb[PIN_DOA] && !clr_any
      && !stb[PIN_RST] && state_reg != ST_OFF
      |=> scan_o && $stable(base_addr_o))
    else $error("prompt while running misbehaved");

  a_doc_starts: assert property (stb[PIN_DOC] && !clr_any
      |=> state_reg == ST_RUN ##1 xfer_grant_o)
    else $error("start did not run the core");

  a_pause_boundary: assert property (s_pause_taken ##0 s_still_serving
      |=> !xfer_grant_o && state_reg == ST_PAUSING)
    else $error("pause did not wait for port boundary");

  a_ovf_flush: assert property (stb[PIN_STA] && ovf_reg && !st_push
      |=> st_empty && !ovf_reg)
    else $error("start after overflow did not empty stack");

  a_pop_empty_done: assert property (st_pop && st_count == 6'h01
      && !st_push && !ovf_reg && !rtc_flag_reg && !rtc_tick
      |=> ##1 !done_o)
    else $error("done stayed after last entry popped");

endmodule : mhic_host_ctrl

// ---- testbench/mhic_cpu_model.sv ----
`timescale 1ns/100ps
// cpu side: raises the lanes of one i/o instruction for three clocks,
// with the data word set up four clocks ahead and held through the edge
module mhic_cpu_model (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        go_i,
  input  wire logic [7:0]  lanes_i,
  input  wire logic [15:0] word_i,
  output logic      [7:0]  pins_o,
  output logic      [15:0] data_bus_o,
  output logic             idle_o
);
  logic [3:0] step_reg;
  logic [7:0] lanes_reg;

  assign idle_o = (step_reg == 4'h0);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step_reg <= 4'h0;
    end else if (idle_o) begin
      step_reg <= go_i ? 4'h1 : 4'h0;
    end else begin
      step_reg <= (step_reg == 4'ha) ? 4'h0 : step_reg + 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lanes_reg <= 8'h00;
      pins_o    <= 8'h00;
    end else begin
      if (idle_o && go_i) lanes_reg <= lanes_i;
      if (step_reg == 4'h4) pins_o <= lanes_reg;
      if (step_reg == 4'h7) pins_o <= 8'h00;
    end
  end

  // a released bus shows the inverse so stale data never looks valid
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_bus_o <= 16'h0000;
    end else if (idle_o && go_i) begin
      data_bus_o <= word_i;
    end else if (step_reg == 4'ha) begin
      data_bus_o <= ~data_bus_o;
    end
  end
endmodule : mhic_cpu_model

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module testbench;
  import mhic_pkg::*;
  localparam int unsigned RTC_N  = 200;
  localparam int unsigned SCAN_N = 400;
  localparam logic [7:0] L_RST = 8'h01 << PIN_RST, L_CLR = 8'h01 << PIN_CLR;
  localparam logic [7:0] L_PLS = 8'h01 << PIN_PLS, L_STA = 8'h01 << PIN_STA;
  localparam logic [7:0] L_DOA = 8'h01 << PIN_DOA, L_DOB = 8'h01 << PIN_DOB;
  localparam logic [7:0] L_DOC = 8'h01 << PIN_DOC, L_DIA = 8'h01 << PIN_DIA;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic [7:0]  pins, lanes = 8'h00;
  logic [15:0] dbus, word = 16'h0000, sw, base;
  logic        go = 1'b0, idle, rv = 1'b0, rin = 1'b0, rout = 1'b0;
  logic [6:0]  rport = 7'h00;
  logic [2:0]  strap = 3'h5, crate;
  logic [3:0]  cfmt;
  logic        in_svc = 1'b0, grant, done, busy, intr, rtc, scan, abort;
  logic        ctl, cload;
  int num_errors = 0, checks_done = 0, cycles = 0, n = 0, k = 0;
  int scan_cnt = 0, abort_cnt = 0, ctl_cnt = 0, intr_cnt = 0, cload_cnt = 0;

  mhic_host_ctrl #(.RTC_CYCLES(RTC_N), .SCAN_CYCLES(SCAN_N))
    mhic_host_ctrl_inst (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus_reset_instr_i(pins[PIN_RST]),
    .no_xfer_clear_instr_i(pins[PIN_CLR]), .io_pulse_strobe_i(pins[PIN_PLS]),
    .no_xfer_start_instr_i(pins[PIN_STA]), .data_out_a_instr_i(pins[PIN_DOA]),
    .data_out_b_instr_i(pins[PIN_DOB]), .data_out_c_instr_i(pins[PIN_DOC]),
    .data_in_a_instr_i(pins[PIN_DIA]), .data_bus_i(dbus),
    .console_rate_strap_i(strap), .report_valid_i(rv),
    .report_in_done_i(rin), .report_out_done_i(rout), .report_port_i(rport),
    .port_in_service_i(in_svc), .status_word_o(sw), .base_addr_o(base),
    .xfer_grant_o(grant), .done_o(done), .busy_o(busy), .intr_o(intr),
    .rtc_run_o(rtc), .scan_o(scan), .abort_tx_o(abort),
    .ctrl_assert_o(ctl), .console_load_o(cload), .console_rate_o(crate),
    .console_fmt_o(cfmt));

  mhic_cpu_model mhic_cpu_model_inst (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .go_i(go), .lanes_i(lanes),
    .word_i(word), .pins_o(pins), .data_bus_o(dbus), .idle_o(idle));

  always #20 clock_i = ~clock_i;

  // pulses counted on the falling edge, away from the launch edge
  always @(negedge clock_i) begin
    scan_cnt  += (scan === 1'b1);
    abort_cnt += (abort === 1'b1);
    ctl_cnt   += (ctl === 1'b1);
    cload_cnt += (cload === 1'b1);
    intr_cnt  += (intr === 1'b1);
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task check_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val

  task finish_test;
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task instr(input logic [7:0] l, input logic [15:0] w);
    @(posedge clock_i);
    lanes <= l;
    word <= w;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    @(posedge clock_i);
    while (idle !== 1'b1) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
  endtask : instr

  task push(input logic i, input logic o, input logic [6:0] p, input int c);
    @(posedge clock_i);
    rv <= 1'b1;
    rin <= i;
    rout <= o;
    rport <= p;
    repeat (c) @(posedge clock_i);
    rv <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : push

  initial begin
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    `CHK(base, BASE_DEFAULT);
    `CHK({busy, done, rtc, crate, cfmt}, {3'h0, RATE_RESET, CONSOLE_FMT});
    apb(1'b0, 12'h00c, 32'h0);
    `CHK({err, rd[15:0]}, 17'h10000);
    instr(L_DOA, 16'h12ab);
    `CHK(base, 16'h1200);
    apb(1'b0, ADDR_BASE, 32'h0);
    `CHK(rd, 32'h1200);
    instr(L_CLR, 16'h0000);
    `CHK({base, crate, ctl_cnt[3:0]}, {16'h1200, RATE_RESET, 4'h0});
    `CHK(abort_cnt, 1);
    `CHK({ctl_cnt[3:0], cload_cnt[3:0]}, 8'h00);
    instr(L_RST, 16'h0000);
    `CHK(base, BASE_DEFAULT);
    `CHK({crate, cfmt, ctl_cnt[3:0]}, {3'h5, CONSOLE_FMT, 4'h1});
    `CHK(abort_cnt, 2);
    `CHK({ctl_cnt[3:0], cload_cnt[3:0]}, 8'h11);
    instr(L_DOA, 16'h12ab);
    instr(L_DOC, 16'h0000);
    `CHK({busy, grant, rtc}, 3'b110);
    n = scan_cnt;
    instr(L_DOA, 16'hffff);
    `CHK({base, 4'(scan_cnt - n)}, {16'h1200, 4'h1});
    n = scan_cnt;
    repeat (2 * SCAN_N) @(posedge clock_i);
    `CHK(scan_cnt - n, 2);
    instr(L_PLS, 16'h0000);
    `CHK({busy, grant, rtc}, 3'b111);
    k = 0;
    while (sw[SW_RTC] !== 1'b1 && k < 3 * RTC_N) begin
      @(posedge clock_i);
      k++;
    end
    `CHK(sw[SW_RTC], 1'b1);
    instr(L_DIA, 16'h0000);
    `CHK(sw[SW_RTC], 1'b0);
    push(1'b1, 1'b0, 7'h05, 1);
    push(1'b0, 1'b1, 7'h09, 1);
    `CHK({done, sw & 16'h7fff}, {1'b1, 16'h20a0});
    instr(L_DOB, 16'h0000);
    n = intr_cnt;
    instr(L_DIA | L_STA, 16'h0000);
    `CHK(sw & 16'h7fff, 16'h1120);
    `CHK({done, 4'(intr_cnt - n)}, {1'b1, 4'h1});
    instr(L_DOC, 16'h0000);
    instr(L_STA, 16'h0000);
    `CHK({done, sw & 16'h7fff}, 17'h0);
    push(1'b1, 1'b0, 7'h11, STACK_DEPTH);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK({sw[SW_OVF], rd[13:8]}, {1'b0, 6'd40});
    push(1'b1, 1'b0, 7'h11, 1);
    `CHK({sw[SW_OVF], sw[11:5]}, 8'h80);
    instr(L_STA, 16'h0000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK({done, rd[13:7]}, 8'h00);
    // pause the core mid port service and read back the control word
    in_svc <= 1'b1;
    n = abort_cnt;
    instr(L_DOB, 16'h0000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd[1:0], 2'b11);
    `CHK({grant, 4'(abort_cnt - n)}, 5'h00);
    in_svc <= 1'b0;
    repeat (3) @(posedge clock_i);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK({busy, rd[1:0]}, 3'b110);
    push(1'b0, 1'b1, 7'h22, 1);
    instr(L_DOC, 16'h0000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK({grant, rd[13:8], rd[1:0]}, {1'b1, 6'd1, 2'b01});
    n = abort_cnt;
    instr(L_CLR, 16'h0000);
    `CHK({busy, done, rtc, grant}, 4'h0);
    `CHK(abort_cnt - n, 1);
    instr(L_DOC | L_PLS, 16'h0000);
    `CHK({busy, rtc}, 2'b11);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clock_i);
    `CHK({busy, rtc}, 2'b00);
    finish_test();
  end
endmodule : testbench
